/* wwd_pkg.sv */
// Constants, register map and state codes of the windowed watchdog
// Contract
// - Stopped unless enabled; mode bits select operation
// - Protected fields discarded while enabled or enabling
// - Protected writes during disabling applied afterwards
// - Power-on loads enable, lock, mode, periods, offset
// - Enable starts; disable only without run lock
// - Normal mode: unserviced time-out resets system
// - Twelve open period codes; service anytime
// - Key write restarts a new period
// - Wrong key value resets system at once
// - Warning irq off by default; set/clear enables
// - Normal mode warning at selected offset
// - Window mode: service while closed resets
// - Closed from window field, open from period
// - Open follows closed; open expiry resets
// - Window mode warning when open period starts
// - Run lock forces running; only power-on clears
// - Run lock freezes timing and warning setup
// - Run lock still allows mode and irq enables
// - Irq stays while flag and enable set
// - Offset beyond time-out: reset first, no warning
// - Control and key writes synchronised; busy stalls the next such write
package wwd_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_CONFIG = 4'h1;
   localparam logic [3:0] IDX_WARN_SETUP = 4'h2;
   localparam logic [3:0] IDX_IRQ_CLR = 4'h4;
   localparam logic [3:0] IDX_IRQ_SET = 4'h5;
   localparam logic [3:0] IDX_IRQ_FLAG = 4'h6;
   localparam logic [3:0] IDX_STATUS = 4'h7;
   localparam logic [3:0] IDX_CLEAR = 4'h8;
   // Field positions
   localparam int BIT_LOCK = 7;
   localparam int BIT_WEN = 2;
   localparam int BIT_EN = 1;
   localparam int BIT_WARN = 0;
   localparam int BIT_BUSY = 7;
   localparam int POS_WIN = 4;
   // Reset values
   localparam logic [3:0] RST_CODE = 4'h0;
   localparam logic RST_BIT = 1'b0;
   // Service key and timing
   localparam logic [7:0] SERVICE_KEY = 8'ha5;
   localparam logic [3:0] CODE_MAX = 4'hb;
   localparam logic [16:0] BASE_CYC = 17'h00008;
   localparam logic [2:0] SYNC_CYC = 3'h4;
   localparam logic [1:0] LOAD_CYC = 2'h2;
   typedef enum logic [2:0] {
      PH_STOP = 3'b001,
      PH_CLOSED = 3'b010,
      PH_OPEN = 3'b100
   } wwd_phase_t;
endpackage : wwd_pkg

/* wwd_top.sv */
// Windowed watchdog timer with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module wwd_top import wwd_pkg::*; (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Counting clock pin, sampled
   input wire logic watchdog_count_clock,
   // Nonvolatile power-on values
   input wire logic nvm_enable,
   input wire logic nvm_run_lock,
   input wire logic nvm_window_mode,
   input wire logic [3:0] nvm_closed_select,
   input wire logic [3:0] nvm_open_select,
   input wire logic [3:0] nvm_warning_offset,
   // System outputs
   output logic sys_reset_req,
   output logic early_warning_irq
);
   // Bus state
   logic dp_valid_q;
   logic dp_write_q;
   logic dp_map_q;
   logic [3:0] dp_idx_q;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   // Configuration
   logic enable_q;
   logic persistent_run_lock_q;
   logic window_mode_q;
   logic [3:0] closed_select_q;
   logic [3:0] open_period_select_q;
   logic [3:0] early_warning_offset_q;
   logic warn_ien_q;
   logic warn_flag_q;
   // Held writes during disabling
   logic hold_cfg_v_q;
   logic [7:0] hold_cfg_q;
   logic hold_warn_v_q;
   logic [3:0] hold_warn_q;
   // Synchronisation
   logic domain_sync_pending_q;
   logic [2:0] sync_cnt_q;
   logic pend_is_ctrl_q;
   logic [7:0] pend_data_q;
   // Count clock sampler
   logic cclk_s1_q;
   logic cclk_s2_q;
   logic cclk_s3_q;
   // Power-on load
   logic [16:0] nvm_s1_q;
   logic [16:0] nvm_s2_q;
   logic [1:0] load_cnt_q;
   logic load_done_q;
   // Timer
   wwd_phase_t phase_q;
   logic win_run_q;
   logic [16:0] cnt_q;
   logic sys_reset_q;
   logic irq_q;

   logic ap_take;
   logic wr_end;
   logic is_sync_idx;
   logic sync_go;
   logic sync_done;
   logic run;
   logic tick;
   logic disabling;
   logic protect;
   logic service_ok;
   logic service_bad;
   logic [7:0] wbyte;
   logic [16:0] open_cyc;
   logic [16:0] closed_cyc;
   logic [16:0] warn_cyc;
   logic [16:0] cnt_inc;

   function automatic logic [16:0] code_cycles(input logic [3:0] code);
      logic [3:0] c;
      c = (code > CODE_MAX) ? CODE_MAX : code;
      code_cycles = BASE_CYC << c;
   endfunction : code_cycles

   assign ap_take = hsel & htrans[1] & hready;
   assign wr_end = dp_valid_q & dp_write_q & dp_map_q & hreadyout_q;
   assign is_sync_idx = (dp_idx_q == IDX_CTRL) | (dp_idx_q == IDX_CLEAR);
   assign sync_go = wr_end & is_sync_idx;
   assign sync_done = domain_sync_pending_q & (sync_cnt_q == 3'h0);
   assign wbyte = hwdata[7:0];
   assign run = load_done_q & (enable_q | persistent_run_lock_q);
   assign tick = cclk_s2_q & ~cclk_s3_q;
   assign disabling = domain_sync_pending_q & pend_is_ctrl_q & enable_q & ~pend_data_q[BIT_EN]
      & ~persistent_run_lock_q;
   assign protect = persistent_run_lock_q | enable_q
      | (domain_sync_pending_q & pend_is_ctrl_q & pend_data_q[BIT_EN]);
   assign service_ok = sync_done & ~pend_is_ctrl_q & (pend_data_q == SERVICE_KEY);
   assign service_bad = sync_done & ~pend_is_ctrl_q & (pend_data_q != SERVICE_KEY);
   assign open_cyc = code_cycles(open_period_select_q);
   assign closed_cyc = code_cycles(closed_select_q);
   assign warn_cyc = code_cycles(early_warning_offset_q);
   assign cnt_inc = cnt_q + 17'h00001;

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_map_q <= 1'b0;
         dp_idx_q <= 4'h0;
      end else if (ap_take) begin
         dp_valid_q <= 1'b1;
         dp_write_q <= hwrite;
         dp_map_q <= (haddr[11:6] == 6'h00) & (haddr[1:0] == 2'h0);
         dp_idx_q <= haddr[5:2];
      end else if (hreadyout_q) begin
         dp_valid_q <= 1'b0;
      end
   end

   // Ready: stall a synchronised write while a sync is under way
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
      end else if (ap_take) begin
         hreadyout_q <= ~(hwrite & (haddr[11:6] == 6'h00) & (haddr[1:0] == 2'h0)
            & ((haddr[5:2] == IDX_CTRL) | (haddr[5:2] == IDX_CLEAR))
            & (domain_sync_pending_q | sync_go));
      end else if (!hreadyout_q && !domain_sync_pending_q) begin
         hreadyout_q <= 1'b1;
      end
   end

   // Read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (ap_take && !hwrite) begin
         hrdata_q <= 32'h00000000;
         if (haddr[11:6] == 6'h00) begin
            unique case (haddr[5:2])
               IDX_CTRL: begin
                  hrdata_q[BIT_LOCK] <= persistent_run_lock_q;
                  hrdata_q[BIT_WEN] <= window_mode_q;
                  hrdata_q[BIT_EN] <= enable_q;
               end
               IDX_CONFIG: hrdata_q[7:0] <= {closed_select_q, open_period_select_q};
               IDX_WARN_SETUP: hrdata_q[3:0] <= early_warning_offset_q;
               IDX_IRQ_CLR, IDX_IRQ_SET: hrdata_q[BIT_WARN] <= warn_ien_q;
               IDX_IRQ_FLAG: hrdata_q[BIT_WARN] <= warn_flag_q;
               IDX_STATUS: hrdata_q[BIT_BUSY] <= domain_sync_pending_q;
               default: hrdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // Synchroniser of control and key writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         domain_sync_pending_q <= 1'b0;
         sync_cnt_q <= 3'h0;
         pend_is_ctrl_q <= 1'b0;
         pend_data_q <= 8'h00;
      end else if (sync_go) begin
         domain_sync_pending_q <= 1'b1;
         sync_cnt_q <= SYNC_CYC - 3'h1;
         pend_is_ctrl_q <= (dp_idx_q == IDX_CTRL);
         pend_data_q <= wbyte;
      end else if (sync_done) begin
         domain_sync_pending_q <= 1'b0;
      end else if (domain_sync_pending_q) begin
         sync_cnt_q <= sync_cnt_q - 3'h1;
      end
   end

   // Count clock pin sampler
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cclk_s1_q <= 1'b0;
         cclk_s2_q <= 1'b0;
         cclk_s3_q <= 1'b0;
      end else begin
         cclk_s1_q <= watchdog_count_clock;
         cclk_s2_q <= cclk_s1_q;
         cclk_s3_q <= cclk_s2_q;
      end
   end

   // Nonvolatile values sampled after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nvm_s1_q <= 17'h00000;
         nvm_s2_q <= 17'h00000;
         load_cnt_q <= 2'h0;
         load_done_q <= 1'b0;
      end else begin
         nvm_s1_q <= {nvm_enable, nvm_run_lock, nvm_window_mode, nvm_closed_select,
            nvm_open_select, nvm_warning_offset, 2'h0};
         nvm_s2_q <= nvm_s1_q;
         if (load_cnt_q != LOAD_CYC) begin
            load_cnt_q <= load_cnt_q + 2'h1;
         end else begin
            load_done_q <= 1'b1;
         end
      end
   end

   // Control bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_q <= RST_BIT;
         persistent_run_lock_q <= RST_BIT;
         window_mode_q <= RST_BIT;
      end else if (!load_done_q && load_cnt_q == LOAD_CYC) begin
         enable_q <= nvm_s2_q[16];
         persistent_run_lock_q <= nvm_s2_q[15];
         window_mode_q <= nvm_s2_q[14];
      end else if (sync_done && pend_is_ctrl_q) begin
         if (persistent_run_lock_q) begin
            window_mode_q <= pend_data_q[BIT_WEN];
         end else if (enable_q) begin
            enable_q <= pend_data_q[BIT_EN];
         end else begin
            enable_q <= pend_data_q[BIT_EN];
            window_mode_q <= pend_data_q[BIT_WEN];
            persistent_run_lock_q <= pend_data_q[BIT_LOCK];
         end
      end
   end

   // Timing setup registers with held writes while disabling
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         closed_select_q <= RST_CODE;
         open_period_select_q <= RST_CODE;
         early_warning_offset_q <= RST_CODE;
         hold_cfg_v_q <= 1'b0;
         hold_cfg_q <= 8'h00;
         hold_warn_v_q <= 1'b0;
         hold_warn_q <= 4'h0;
      end else if (!load_done_q && load_cnt_q == LOAD_CYC) begin
         closed_select_q <= nvm_s2_q[13:10];
         open_period_select_q <= nvm_s2_q[9:6];
         early_warning_offset_q <= nvm_s2_q[5:2];
      end else begin
         if (wr_end && dp_idx_q == IDX_CONFIG) begin
            if (disabling) begin
               hold_cfg_v_q <= 1'b1;
               hold_cfg_q <= wbyte;
            end else if (!protect) begin
               closed_select_q <= wbyte[7:POS_WIN];
               open_period_select_q <= wbyte[3:0];
            end
         end
         if (wr_end && dp_idx_q == IDX_WARN_SETUP) begin
            if (disabling) begin
               hold_warn_v_q <= 1'b1;
               hold_warn_q <= wbyte[3:0];
            end else if (!protect) begin
               early_warning_offset_q <= wbyte[3:0];
            end
         end
         if (sync_done && disabling) begin
            hold_cfg_v_q <= 1'b0;
            hold_warn_v_q <= 1'b0;
            if (hold_cfg_v_q) begin
               closed_select_q <= hold_cfg_q[7:POS_WIN];
               open_period_select_q <= hold_cfg_q[3:0];
            end
            if (hold_warn_v_q) begin
               early_warning_offset_q <= hold_warn_q;
            end
         end else if (sync_done && pend_is_ctrl_q) begin
            hold_cfg_v_q <= 1'b0;
            hold_warn_v_q <= 1'b0;
         end
      end
   end

   // Interrupt enable, off after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warn_ien_q <= 1'b0;
      end else if (wr_end && dp_idx_q == IDX_IRQ_SET && wbyte[BIT_WARN]) begin
         warn_ien_q <= 1'b1;
      end else if (wr_end && dp_idx_q == IDX_IRQ_CLR && wbyte[BIT_WARN]) begin
         warn_ien_q <= 1'b0;
      end
   end

   // Timer phases and counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= PH_STOP;
         win_run_q <= 1'b0;
         cnt_q <= 17'h00000;
      end else if (!run) begin
         phase_q <= PH_STOP;
         cnt_q <= 17'h00000;
      end else begin
         unique case (phase_q)
            PH_STOP: begin
               cnt_q <= 17'h00000;
               win_run_q <= window_mode_q;
               phase_q <= window_mode_q ? PH_CLOSED : PH_OPEN;
            end
            PH_CLOSED: begin
               if (service_ok) begin
                  cnt_q <= 17'h00000;
               end else if (tick && cnt_inc == closed_cyc) begin
                  cnt_q <= 17'h00000;
                  phase_q <= PH_OPEN;
               end else if (tick) begin
                  cnt_q <= cnt_inc;
               end
            end
            PH_OPEN: begin
               if (service_ok) begin
                  cnt_q <= 17'h00000;
                  win_run_q <= window_mode_q;
                  phase_q <= window_mode_q ? PH_CLOSED : PH_OPEN;
               end else if (tick) begin
                  cnt_q <= cnt_inc;
               end
            end
         endcase
      end
   end

   // Early warning flag; a set beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warn_flag_q <= 1'b0;
      end else if (run && tick && phase_q == PH_CLOSED && cnt_inc == closed_cyc) begin
         warn_flag_q <= 1'b1;
      end else if (run && tick && phase_q == PH_OPEN && !win_run_q && !service_ok
            && cnt_inc == warn_cyc && warn_cyc < open_cyc) begin
         warn_flag_q <= 1'b1;
      end else if (wr_end && dp_idx_q == IDX_IRQ_FLAG && wbyte[BIT_WARN]) begin
         warn_flag_q <= 1'b0;
      end
   end

   // System reset request, held until the next power-on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_reset_q <= 1'b0;
      end else if (run && phase_q == PH_OPEN && tick && !service_ok && cnt_inc == open_cyc) begin
         sys_reset_q <= 1'b1;
      end else if (run && phase_q == PH_CLOSED && service_ok) begin
         sys_reset_q <= 1'b1;
      end else if (run && service_bad) begin
         sys_reset_q <= 1'b1;
      end
   end

   // Interrupt request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= warn_flag_q & warn_ien_q;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign sys_reset_req = sys_reset_q;
   assign early_warning_irq = irq_q;
endmodule : wwd_top
`default_nettype wire

/* wwd_props.sv */
// Assertion checker of the windowed watchdog ports
`timescale 1ns/1ns
`default_nettype none
module wwd_props import wwd_pkg::*; (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Outputs
   input wire logic sys_reset_req,
   input wire logic early_warning_irq
);
   logic tk, wd, sw, dp_q, dw_q, ie_q;
   logic [3:0] ix_q, cs_q;
   assign tk = hsel && htrans[1] && hready;
   assign wd = dp_q && dw_q && hreadyout;
   assign sw = dp_q && dw_q && (ix_q == IDX_CTRL || ix_q == IDX_CLEAR);
   // Data phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q <= 1'b0;
         dw_q <= 1'b0;
         ix_q <= 4'h0;
      end else if (hready) begin
         dp_q <= tk;
         dw_q <= hwrite;
         ix_q <= haddr[5:2];
      end
   end
   // Recent flag or enable clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cs_q <= 4'h0;
      else cs_q <= {cs_q[2:0], wd && hwdata[BIT_WARN] && (ix_q == IDX_IRQ_CLR || ix_q == IDX_IRQ_FLAG)};
   end
   // Irq enable seen since reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ie_q <= 1'b0;
      else if (wd && hwdata[BIT_WARN] && ix_q == IDX_IRQ_SET) ie_q <= 1'b1;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_reset_sticky: assert property (sys_reset_req |=> sys_reset_req)
      else $error("reset request dropped");
   a_stall_cause: assert property (!hreadyout |-> sw)
      else $error("stall outside a synchronised write");
   a_stall_bound: assert property ($fell(hreadyout) |-> ##[1:6] hreadyout)
      else $error("stall too long");
   a_busy_stall: assert property (sw && hreadyout ##[0:2] (tk && hwrite &&
      (haddr[5:2] == IDX_CTRL || haddr[5:2] == IDX_CLEAR)) |=> !hreadyout)
      else $error("second synchronised write not stalled");
   a_busy_flag: assert property (sw && hreadyout ##1 (tk && !hwrite && haddr[5:2] == IDX_STATUS)
      |=> hrdata[BIT_BUSY]) else $error("busy flag not set");
   a_irq_fall: assert property ($fell(early_warning_irq) |-> |cs_q)
      else $error("irq dropped without clear");
   a_irq_enabled: assert property ($rose(early_warning_irq) |-> ie_q)
      else $error("irq raised while disabled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   cover property ($rose(sys_reset_req));
   cover property ($rose(early_warning_irq));
   cover property ($fell(hreadyout));
endmodule : wwd_props
bind wwd_top wwd_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .sys_reset_req, .early_warning_irq);
`default_nettype wire

/* tb_windowed_watchdog_timer.sv */
// Directed testbench of the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
module tb_windowed_watchdog_timer import wwd_pkg::*; ;
   logic hclk, hresetn, hsel, hwrite, watchdog_count_clock, nvm_enable, nvm_run_lock, nvm_window_mode;
   logic [3:0] nvm_closed_select, nvm_open_select, nvm_warning_offset;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, div;
   logic [2:0] hsize;
   logic hreadyout, hresp, sys_reset_req, early_warning_irq;
   wire logic hready;
   int fail_count, total_checks;
   assign hready = hreadyout;
   wwd_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .watchdog_count_clock, .nvm_enable, .nvm_run_lock, .nvm_window_mode,
      .nvm_closed_select, .nvm_open_select, .nvm_warning_offset, .sys_reset_req, .early_warning_irq);
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Count clock at a quarter of the bus clock
   always @(posedge hclk) begin
      div <= div + 2'h1;
      watchdog_count_clock <= div[1];
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic [3:0] i, input logic w, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {26'h0, i, 2'b00};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task automatic rc(input string nm, input logic [3:0] i, input logic [7:0] e);
      bus(i, 1'b0, 8'h00);
      chk(nm, {24'h0, e}, rd);
   endtask : rc
   // Cycles until reset request or irq, within bounds
   task automatic wt(input string nm, input bit q, input int lo, input int hi);
      int n;
      n = 0;
      while ((q ? early_warning_irq : sys_reset_req) !== 1'b1 && n <= hi) begin
         @(posedge hclk);
         n++;
      end
      total_checks++;
      if (n < lo || n > hi) begin
         fail_count++;
         $display("mismatch %s expected %0d to %0d seen %0d", nm, lo, hi, n);
      end
   endtask : wt
   task automatic por();
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
   endtask : por
   task automatic t_nvm();
      {nvm_enable, nvm_run_lock, nvm_window_mode} <= 3'h7;
      {nvm_closed_select, nvm_open_select, nvm_warning_offset} <= {4'h1, 4'h1, 4'h3};
      por();
      rc("config", IDX_CONFIG, 8'h11);
      rc("offset", IDX_WARN_SETUP, 8'h03);
      rc("control", IDX_CTRL, 8'h86);
      wt("nvm timeout", 1'b0, 108, 136);
      {nvm_enable, nvm_run_lock, nvm_window_mode} <= 3'h0;
      {nvm_closed_select, nvm_open_select, nvm_warning_offset} <= 12'h000;
      $display("test nvm done");
   endtask : t_nvm
   task automatic t_prot();
      por();
      bus(IDX_CLEAR, 1'b1, 8'h5a);
      repeat (60) @(posedge hclk);
      chk("stopped", 32'h0, 32'(sys_reset_req));
      bus(IDX_CONFIG, 1'b1, 8'h03);
      bus(IDX_CTRL, 1'b1, 8'h02);
      rc("busy", IDX_STATUS, 8'h80);
      bus(IDX_CONFIG, 1'b1, 8'h55);
      rc("guarded", IDX_CONFIG, 8'h03);
      bus(IDX_CTRL, 1'b1, 8'h06);
      bus(IDX_CTRL, 1'b1, 8'h00);
      bus(IDX_CONFIG, 1'b1, 8'h10);
      repeat (8) @(posedge hclk);
      rc("held", IDX_CONFIG, 8'h10);
      rc("control", IDX_CTRL, 8'h00);
      bus(4'h3, 1'b1, 8'hff);
      rc("unmapped", 4'h3, 8'h00);
      repeat (300) @(posedge hclk);
      chk("disabled", 32'h0, 32'(sys_reset_req));
      $display("test protect done");
   endtask : t_prot
   task automatic t_norm();
      por();
      bus(IDX_WARN_SETUP, 1'b1, 8'h03);
      bus(IDX_IRQ_SET, 1'b1, 8'h01);
      bus(IDX_CTRL, 1'b1, 8'h02);
      wt("timeout", 1'b0, 32, 48);
      repeat (260) @(posedge hclk);
      chk("late warning", 32'h0, 32'(early_warning_irq));
      $display("test normal done");
   endtask : t_norm
   task automatic t_svc();
      por();
      bus(IDX_CONFIG, 1'b1, 8'h01);
      bus(IDX_CTRL, 1'b1, 8'h02);
      repeat (3) begin
         repeat (50) @(posedge hclk);
         bus(IDX_CLEAR, 1'b1, SERVICE_KEY);
      end
      chk("serviced", 32'h0, 32'(sys_reset_req));
      bus(IDX_CLEAR, 1'b1, 8'h5a);
      wt("wrong key", 1'b0, 1, 12);
      $display("test service done");
   endtask : t_svc
   task automatic t_ew();
      por();
      rc("irq default", IDX_IRQ_SET, 8'h00);
      bus(IDX_CONFIG, 1'b1, 8'h02);
      bus(IDX_IRQ_SET, 1'b1, 8'h01);
      bus(IDX_CTRL, 1'b1, 8'h02);
      wt("warning", 1'b1, 32, 48);
      bus(IDX_IRQ_CLR, 1'b1, 8'h01);
      repeat (3) @(posedge hclk);
      chk("masked", 32'h0, 32'(early_warning_irq));
      bus(IDX_IRQ_SET, 1'b1, 8'h01);
      repeat (3) @(posedge hclk);
      chk("unmasked", 32'h1, 32'(early_warning_irq));
      bus(IDX_IRQ_FLAG, 1'b1, 8'h01);
      repeat (3) @(posedge hclk);
      chk("cleared", 32'h0, 32'(early_warning_irq));
      wt("warned timeout", 1'b0, 60, 100);
      $display("test warning done");
   endtask : t_ew
   task automatic t_win();
      por();
      bus(IDX_CONFIG, 1'b1, 8'h10);
      bus(IDX_IRQ_SET, 1'b1, 8'h01);
      bus(IDX_CTRL, 1'b1, 8'h06);
      wt("open start", 1'b1, 64, 80);
      wt("open expiry", 1'b0, 24, 40);
      por();
      bus(IDX_CONFIG, 1'b1, 8'h10);
      bus(IDX_CTRL, 1'b1, 8'h06);
      repeat (76) @(posedge hclk);
      bus(IDX_CLEAR, 1'b1, SERVICE_KEY);
      repeat (6) @(posedge hclk);
      chk("open service", 32'h0, 32'(sys_reset_req));
      bus(IDX_CLEAR, 1'b1, SERVICE_KEY);
      wt("closed service", 1'b0, 1, 12);
      $display("test window done");
   endtask : t_win
   task automatic t_lock();
      por();
      bus(IDX_CTRL, 1'b1, 8'h80);
      repeat (6) @(posedge hclk);
      bus(IDX_CONFIG, 1'b1, 8'h33);
      bus(IDX_CTRL, 1'b1, 8'h04);
      bus(IDX_IRQ_SET, 1'b1, 8'h01);
      rc("lock irq", IDX_IRQ_SET, 8'h01);
      rc("lock config", IDX_CONFIG, 8'h00);
      bus(IDX_CTRL, 1'b0, 8'h00);
      chk("lock bits", 32'h84, rd & 32'h84);
      wt("lock timeout", 1'b0, 12, 28);
      por();
      rc("power on", IDX_CTRL, 8'h00);
      $display("test lock done");
   endtask : t_lock
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   initial begin
      {hresetn, hsel, hwrite, div, watchdog_count_clock, htrans, haddr, hwdata} = '0;
      {nvm_enable, nvm_run_lock, nvm_window_mode, nvm_closed_select, nvm_open_select, nvm_warning_offset} = '0;
      hsize = 3'h2;
      t_nvm();
      t_prot();
      t_norm();
      t_svc();
      t_ew();
      t_win();
      t_lock();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      $display("mismatch run time expected end seen timeout");
      test_done();
   end
endmodule : tb_windowed_watchdog_timer
`default_nettype wire
